// ==== rtl/table_read_pkg.sv ====
// constants shared by the table read path and its program memory
package table_read_pkg;
  localparam int ADDR_W = 12;                    // 4K words
  localparam int WORD_W = 16;                    // program word width
  localparam int HIGH_USED_W = 8;                // implemented high bits
  localparam logic [7:0] PTR_LO_RST = 8'h00;
  localparam logic [7:0] PTR_HI_RST = 8'h00;
  localparam logic [7:0] HIGH_LATCH_RST = 8'h00;
  localparam logic [11:0] LAST_PAGE_BASE = 12'h0F00;
  localparam int TABLE_CYCLES = 2;               // instruction cycles
  localparam int INSTR_CLKS = 4;                 // sys_clk per instruction cycle
  typedef enum logic [1:0]
  {
    OP_TABLE_READ,
    OP_TABLE_READ_ALT,
    OP_EXT_TABLE_READ,
    OP_EXT_TABLE_READ_ALT
  } table_op_t;
endpackage : table_read_pkg

// ==== rtl/prog_word_mem.sv ====
// program memory array with a registered read port and a write port
`timescale 1ns/1ps
module prog_word_mem #(
  parameter int ADDR_W = 12,
  parameter int WORD_W = 16
) (
  // clock
  input wire logic sys_clk,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data,
  // write port for loading contents
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // write and registered read in one cycle; a same-address read returns the old word
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : prog_word_mem

// ==== rtl/program_memory_table_read.sv ====
// table read path: pointer, program word fetch, low and high byte delivery
`timescale 1ns/1ps

module program_memory_table_read #(
  parameter int ADDR_W = table_read_pkg::ADDR_W,
  parameter int WORD_W = table_read_pkg::WORD_W,
  parameter int HIGH_USED_W = table_read_pkg::HIGH_USED_W,
  parameter int INSTR_CLKS = table_read_pkg::INSTR_CLKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pointer writes from the core
  input wire logic ptr_lo_we,
  input wire logic ptr_hi_we,
  input wire logic [7:0] ptr_wdata,
  // holding register software access
  input wire logic high_latch_we,
  input wire logic [7:0] high_latch_wdata,
  // table read request
  input wire logic tbl_start,
  input wire table_read_pkg::table_op_t tbl_op,
  input wire logic [7:0] tbl_dest_addr,
  input wire logic [1:0] tbl_dest_sector,
  // memory load port (programming path)
  input wire logic prog_we,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [WORD_W-1:0] prog_wdata,
  // results
  output logic [7:0] ptr_lo_ff,
  output logic [7:0] ptr_hi_ff,
  output logic [7:0] table_high_latch_ff,
  output logic dmem_we_ff,
  output logic [7:0] dmem_addr_ff,
  output logic [1:0] dmem_sector_ff,
  output logic [7:0] dmem_wdata_ff,
  output logic tbl_busy_ff,
  output logic tbl_done_ff,
  output logic tbl_op_err_ff
);
  localparam int TOTAL_CLKS = table_read_pkg::TABLE_CYCLES * INSTR_CLKS;
  localparam int CNT_W = $clog2(TOTAL_CLKS + 1);

  // parameters the logic cannot serve, refused at elaboration
  if (WORD_W != 16 || ADDR_W < 1 || ADDR_W > 16 || INSTR_CLKS < 2 ||
      HIGH_USED_W < 1 || HIGH_USED_W > 8)
  begin : bad_params
    $error("program_memory_table_read: unsupported parameters");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_FINISH} tbl_state_t;

  tbl_state_t state_ff;
  tbl_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_word;
  logic [7:0] dest_addr_ff;
  logic [1:0] dest_sector_ff;
  logic is_ext_ff;

  // keep only the implemented high bits
  function automatic logic [7:0] mask_high(input logic [7:0] b);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = (i < HIGH_USED_W) ? b[i] : 1'b0;
    end
    return m;
  endfunction : mask_high

  function automatic logic op_is_ext(input table_read_pkg::table_op_t op);
    return (op == table_read_pkg::OP_EXT_TABLE_READ) ||
           (op == table_read_pkg::OP_EXT_TABLE_READ_ALT);
  endfunction : op_is_ext

  // full word address from both pointer bytes, covers the last page
  assign rd_addr = ADDR_W'({ptr_hi_ff, ptr_lo_ff});

  prog_word_mem #(
    .ADDR_W(ADDR_W),
    .WORD_W(WORD_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .rd_addr(rd_addr),
    .rd_data(rd_word), // 16-bit word
    .wr_en(prog_we), // load port in place of serial programming
    .wr_addr(prog_addr),
    .wr_data(prog_wdata)
  );

  // pointer bytes change only on software writes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ptr_lo_ff <= table_read_pkg::PTR_LO_RST;
      ptr_hi_ff <= table_read_pkg::PTR_HI_RST;
    end
    else
    begin
      if (ptr_lo_we)
      begin
        ptr_lo_ff <= ptr_wdata;
      end
      if (ptr_hi_we)
      begin
        ptr_hi_ff <= ptr_wdata;
      end
    end
  end

  // sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (tbl_start)
        begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (cnt_ff == CNT_W'(TOTAL_CLKS - 2))
        begin
          nxt_state = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state and two-instruction-cycle counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE)
      begin
        cnt_ff <= '0;
      end
      else
      begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  // capture destination and instruction form at start
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dest_addr_ff <= 8'h00;
      dest_sector_ff <= 2'b00;
      is_ext_ff <= 1'b0;
      tbl_op_err_ff <= 1'b0;
    end
    else if (state_ff == ST_IDLE && tbl_start)
    begin
      dest_addr_ff <= tbl_dest_addr;
      is_ext_ff <= op_is_ext(tbl_op);
      // basic forms reach sector 0 only; extended forms any sector
      dest_sector_ff <= op_is_ext(tbl_op) ?
                        tbl_dest_sector : 2'b00;
      tbl_op_err_ff <= !op_is_ext(tbl_op) &&
                       (tbl_dest_sector != 2'b00);
    end
  end

  // holding register: software access and table load
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      table_high_latch_ff <= table_read_pkg::HIGH_LATCH_RST;
    end
    else if (state_ff == ST_FINISH)
    begin
      table_high_latch_ff <= mask_high(rd_word[15:8]);
    end
    else if (high_latch_we)
    begin
      table_high_latch_ff <= high_latch_wdata;
    end
  end

  // low byte write to data memory, sector 0 for basic forms, captured sector for extended forms
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dmem_we_ff <= 1'b0;
      dmem_addr_ff <= 8'h00;
      dmem_sector_ff <= 2'b00;
      dmem_wdata_ff <= 8'h00;
      tbl_done_ff <= 1'b0;
    end
    else
    begin
      dmem_we_ff <= (state_ff == ST_FINISH);
      tbl_done_ff <= (state_ff == ST_FINISH);
      if (state_ff == ST_FINISH)
      begin
        dmem_addr_ff <= dest_addr_ff;
        dmem_sector_ff <= is_ext_ff ? dest_sector_ff : 2'b00;
        dmem_wdata_ff <= rd_word[7:0];
      end
    end
  end

  // busy from request to completion
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tbl_busy_ff <= 1'b0;
    end
    else
    begin
      tbl_busy_ff <= (nxt_state != ST_IDLE);
    end
  end
endmodule : program_memory_table_read

// ==== bench/table_read_props.sv ====
// checker for the table read path ports
`timescale 1ns/1ps
module table_read_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // requests
  input wire logic tbl_start,
  input wire table_read_pkg::table_op_t tbl_op,
  input wire logic [7:0] tbl_dest_addr,
  input wire logic [1:0] tbl_dest_sector,
  input wire logic ptr_lo_we,
  input wire logic ptr_hi_we,
  input wire logic [7:0] ptr_wdata,
  // results
  input wire logic [7:0] ptr_lo_ff,
  input wire logic [7:0] ptr_hi_ff,
  input wire logic dmem_we_ff,
  input wire logic [7:0] dmem_addr_ff,
  input wire logic [1:0] dmem_sector_ff,
  input wire logic tbl_busy_ff,
  input wire logic tbl_done_ff
);
  // a request is taken only while idle
  wire logic take = tbl_start && !tbl_busy_ff;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // timing of a read
  busy_span_a: assert property (
    take |=> tbl_busy_ff [*8] ##1 !tbl_busy_ff)
    else $error("busy span wrong");
  done_time_a: assert property (
    take |-> ##9 (tbl_done_ff && dmem_we_ff))
    else $error("done late or early");
  done_pulse_a: assert property (
    tbl_done_ff |=> !tbl_done_ff && !dmem_we_ff)
    else $error("done longer than one cycle");
  // destination of the low byte
  dest_addr_a: assert property (
    take |-> ##9 dmem_addr_ff == $past(tbl_dest_addr, 9))
    else $error("destination address wrong");
  basic_sector_a: assert property (
    take && !tbl_op[1] |-> ##9 dmem_sector_ff == 2'h0)
    else $error("basic form left sector 0");
  ext_sector_a: assert property (
    take && tbl_op[1] |-> ##9
      dmem_sector_ff == $past(tbl_dest_sector, 9))
    else $error("extended form sector wrong");
  // pointer handling
  ptr_keep_a: assert property (
    tbl_busy_ff && !ptr_lo_we && !ptr_hi_we |=>
      $stable(ptr_lo_ff) && $stable(ptr_hi_ff))
    else $error("pointer moved by a read");
  ptr_load_a: assert property (
    ptr_lo_we |=> ptr_lo_ff == $past(ptr_wdata))
    else $error("pointer low byte not loaded");
endmodule : table_read_props

bind program_memory_table_read table_read_props i_table_read_props (.sys_clk,
  .rst, .tbl_start, .tbl_op, .tbl_dest_addr, .tbl_dest_sector, .ptr_lo_we,
  .ptr_hi_we, .ptr_wdata, .ptr_lo_ff, .ptr_hi_ff, .dmem_we_ff, .dmem_addr_ff,
  .dmem_sector_ff, .tbl_busy_ff, .tbl_done_ff);

// ==== bench/table_core_model.sv ====
// processor core model issuing table read requests
`timescale 1ns/1ps
module table_core_model (
  // clock and status
  input wire logic sys_clk,
  input wire logic tbl_busy_ff,
  // request
  output logic tbl_start,
  output table_read_pkg::table_op_t tbl_op,
  output logic [7:0] tbl_dest_addr,
  output logic [1:0] tbl_dest_sector
);
  // idle values at time zero
  initial
  begin
    tbl_start = 1'b0;
    tbl_op = table_read_pkg::OP_TABLE_READ;
    tbl_dest_addr = 8'h00;
    tbl_dest_sector = 2'h0;
  end
  // one read, issued only while idle; destination address and sector scrambled afterwards
  task automatic issue(input table_read_pkg::table_op_t op,
    input logic [7:0] dst, input logic [1:0] sec);
    @(negedge sys_clk);
    while (tbl_busy_ff !== 1'b0) @(negedge sys_clk);
    tbl_start = 1'b1;
    tbl_op = op;
    tbl_dest_addr = dst;
    tbl_dest_sector = sec;
    @(negedge sys_clk);
    tbl_start = 1'b0;
    tbl_dest_addr = ~dst;
    tbl_dest_sector = ~sec;
  endtask : issue
endmodule : table_core_model

// ==== bench/program_memory_table_read_tb_top.sv ====
// testbench for the table read path
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module program_memory_table_read_tb_top;
  logic sys_clk = 1'b0;
  logic rst, ptr_lo_we, ptr_hi_we, high_latch_we, prog_we, tbl_start;
  logic dmem_we_ff, tbl_busy_ff, tbl_done_ff, tbl_op_err_ff;
  logic [7:0] ptr_wdata, high_latch_wdata, tbl_dest_addr, ptr_lo_ff;
  logic [7:0] ptr_hi_ff, table_high_latch_ff, dmem_addr_ff, dmem_wdata_ff;
  logic [1:0] tbl_dest_sector, dmem_sector_ff;
  logic [11:0] prog_addr;
  logic [15:0] prog_wdata;
  table_read_pkg::table_op_t tbl_op;
  int failures = 0;
  int checks_done = 0;
  // one high bit left unbacked so the zero fill is exercised
  localparam int HI_USED = 7;
  localparam logic [7:0] HI_MASK = 8'h7F;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  program_memory_table_read #(.HIGH_USED_W(HI_USED))
    i_program_memory_table_read (.sys_clk, .rst,
    .ptr_lo_we, .ptr_hi_we, .ptr_wdata, .high_latch_we, .high_latch_wdata,
    .tbl_start, .tbl_op, .tbl_dest_addr, .tbl_dest_sector, .prog_we,
    .prog_addr, .prog_wdata, .ptr_lo_ff, .ptr_hi_ff, .table_high_latch_ff,
    .dmem_we_ff, .dmem_addr_ff, .dmem_sector_ff, .dmem_wdata_ff,
    .tbl_busy_ff, .tbl_done_ff, .tbl_op_err_ff);
  table_core_model i_table_core_model (.sys_clk, .tbl_busy_ff, .tbl_start,
    .tbl_op, .tbl_dest_addr, .tbl_dest_sector);
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // program word load
  task automatic load(input logic [11:0] a, input logic [15:0] w);
    @(negedge sys_clk);
    prog_we = 1'b1;
    prog_addr = a;
    prog_wdata = w;
    @(negedge sys_clk);
    prog_we = 1'b0;
  endtask : load
  // pointer set through both bytes
  task automatic set_ptr(input logic [11:0] a);
    @(negedge sys_clk);
    ptr_lo_we = 1'b1;
    ptr_wdata = a[7:0];
    @(negedge sys_clk);
    ptr_lo_we = 1'b0;
    ptr_hi_we = 1'b1;
    ptr_wdata = {4'h0, a[11:8]};
    @(negedge sys_clk);
    ptr_hi_we = 1'b0;
    `CHK({ptr_hi_ff[3:0], ptr_lo_ff}, a)
  endtask : set_ptr
  // one read and its results
  task automatic rd(input table_read_pkg::table_op_t op, input logic [7:0] d,
    input logic [1:0] s, input logic [15:0] w, input logic [1:0] es);
    logic [7:0] lo;
    lo = ptr_lo_ff;
    i_table_core_model.issue(op, d, s);
    repeat (12) if (tbl_done_ff !== 1'b1) @(negedge sys_clk);
    `CHK(dmem_we_ff, 1'b1)
    `CHK(dmem_wdata_ff, w[7:0])
    `CHK(table_high_latch_ff, w[15:8] & HI_MASK)
    `CHK(table_high_latch_ff[7], 1'b0)
    `CHK(dmem_addr_ff, d)
    `CHK(dmem_sector_ff, es)
    `CHK(ptr_lo_ff, lo)
  endtask : rd
  // software write of the holding register
  task automatic latch_wr;
    @(negedge sys_clk);
    high_latch_we = 1'b1;
    high_latch_wdata = 8'h3C;
    @(negedge sys_clk);
    high_latch_we = 1'b0;
    `CHK(table_high_latch_ff, 8'h3C)
  endtask : latch_wr
  // watchdog
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    complete_run;
  end
  // main sequence
  initial
  begin
    {rst, ptr_lo_we, ptr_hi_we, high_latch_we, prog_we} = 5'h1F;
    {ptr_lo_we, ptr_hi_we, high_latch_we, prog_we} = 4'h0;
    {ptr_wdata, high_latch_wdata, prog_addr, prog_wdata} = 44'h0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    load(12'hF06, 16'h5A1A);
    load(12'hF05, 16'hC30F);
    load(12'hFFF, 16'hA55A);
    load(12'h000, 16'h1234);
    set_ptr(12'hF06);
    rd(table_read_pkg::OP_TABLE_READ, 8'h10, 2'h0, 16'h5A1A, 2'h0);
    set_ptr(12'hF05);
    rd(table_read_pkg::OP_TABLE_READ_ALT, 8'h11, 2'h1, 16'hC30F, 2'h0);
    `CHK(tbl_op_err_ff, 1'b1)
    set_ptr(12'hFFF);
    rd(table_read_pkg::OP_EXT_TABLE_READ, 8'hFE, 2'h2, 16'hA55A, 2'h2);
    `CHK(tbl_op_err_ff, 1'b0)
    set_ptr(12'h000);
    rd(table_read_pkg::OP_EXT_TABLE_READ_ALT, 8'h01, 2'h3, 16'h1234, 2'h3);
    latch_wr;
    complete_run;
  end
endmodule : program_memory_table_read_tb_top
